// >>> logic/rmlf_top.sv
`timescale 1ns/10ps
module rmlf_top #(
  parameter int ONESHOT_CYCLES = rmlf_pkg::ONESHOT_CYCLES
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [rmlf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [rmlf_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire rmlf_pkg::rmlf_line_in_type  line_in,
  output logic                             ring_detect_output,
  output logic                             current_limit_select,
  output logic                             irq
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  // the analog lines switch with no relation to aclk; two flops each before any logic
  logic [rmlf_pkg::SYNC_W-1:0] sync1_r;
  logic [rmlf_pkg::SYNC_W-1:0] sync2_r;
  wire  [rmlf_pkg::SYNC_W-1:0] line_raw = line_in;

  genvar gi;
  generate
    for (gi = 0; gi < rmlf_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= line_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  rmlf_pkg::rmlf_line_in_type ln;
  assign ln = sync2_r;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0]                  ring_mode_r;
  logic [7:0]                  line_ctrl_r;
  logic [rmlf_pkg::IRQ_W-1:0]  irq_status_r;
  logic [rmlf_pkg::IRQ_W-1:0]  irq_mask_r;
  logic                        rov_sticky_r;
  logic                        rx_overload_interrupt_flag_r;
  logic [2:0]                  live_d_r;
  logic                        ring_out_r;
  logic                        ovl_live_r;
  logic                        dod_r;
  logic                        opd_r;
  logic                        irq_r;

  // ************************************************************
  // axi4-lite handshake state
  // ************************************************************
  logic                        aw_have_r;
  logic                        w_have_r;
  logic [5:0]                  aw_idx_r;
  logic [7:0]                  w_byte_r;
  logic                        w_lane0_r;
  logic                        bvalid_r;
  logic [1:0]                  bresp_r;
  logic                        rvalid_r;
  logic [31:0]                 rdata_r;
  logic [1:0]                  rresp_r;

  assign s_axi_awready = ~aw_have_r & ~bvalid_r;
  assign s_axi_wready  = ~w_have_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // a pending write response holds off both write channels, so one write at most is in flight
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire wr_go   = aw_have_r & w_have_r & ~bvalid_r;
  // lane 0 unstrobed: a mapped address is answered okay but no register changes
  wire wr_en   = wr_go & w_lane0_r;

  wire [5:0] ar_idx = s_axi_araddr[rmlf_pkg::ADDR_W-1:rmlf_pkg::IDX_LSB];
  wire [5:0] aw_idx = s_axi_awaddr[rmlf_pkg::ADDR_W-1:rmlf_pkg::IDX_LSB];

  // write decode
  wire wr_ring   = wr_en && (aw_idx_r == rmlf_pkg::IDX_RING_MODE);
  wire wr_mask   = wr_en && (aw_idx_r == rmlf_pkg::IDX_IRQ_MASK);
  wire wr_rovreg = wr_en && (aw_idx_r == rmlf_pkg::IDX_RX_OVL);
  wire wr_ctrl   = wr_en && (aw_idx_r == rmlf_pkg::IDX_LINE_CTRL);
  // the status registers answer okay to a write and ignore it
  wire wr_hit    = (aw_idx_r == rmlf_pkg::IDX_RING_MODE) || (aw_idx_r == rmlf_pkg::IDX_LINE_STATUS) ||
                   (aw_idx_r == rmlf_pkg::IDX_IRQ_STATUS) || (aw_idx_r == rmlf_pkg::IDX_IRQ_MASK) ||
                   (aw_idx_r == rmlf_pkg::IDX_RX_OVL) || (aw_idx_r == rmlf_pkg::IDX_LINE_CTRL);

  // ************************************************************
  // line status logic
  // ************************************************************
  wire fw_en   = ring_mode_r[rmlf_pkg::RING_FW_BIT];
  wire ring_validation_enable_en = line_ctrl_r[rmlf_pkg::CTL_RING_VALIDATION_ENABLE_BIT];
  assign current_limit_select = line_ctrl_r[rmlf_pkg::CTL_CURRENT_LIMIT_SELECT_BIT];

  // the one-shot runs in every mode; only the select decides whether the pin sees it
  logic oneshot_pulse;
  rmlf_oneshot #(
    .CYCLES (ONESHOT_CYCLES)
  ) u_oneshot (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trigger (ln.ring_threshold_cross),
    .pulse   (oneshot_pulse)
  );

  // enum order follows {validation enable, full-wave enable}
  rmlf_pkg::rmlf_ring_sel_type ring_sel;
  assign ring_sel = rmlf_pkg::rmlf_ring_sel_type'({ring_validation_enable_en, fw_en});

  logic ring_nxt;
  always_comb begin
    case (ring_sel)
      rmlf_pkg::RING_HALF_WAVE: ring_nxt = ln.ring_halfwave;
      rmlf_pkg::RING_FULL_WAVE: ring_nxt = ln.ring_fullwave;
      rmlf_pkg::RING_VALID_ENV: ring_nxt = ln.ring_valid_env;
      default:                  ring_nxt = oneshot_pulse;
    endcase
  end

  // billing tone enable deliberately not an input here
  wire ovl_nxt = ln.rx_level_excess & ln.offhook_count_done;
  wire dod_nxt = (ln.offhook & ~ln.loop_current) |
                 (~ln.offhook & ln.line_side_enabled);
  // the comparator sits in the analog side; its 160 mA threshold applies for either select value
  wire opd_nxt = ln.overcurrent;

  // ************************************************************
  // sticky overload and interrupts
  // ************************************************************
  // set beats a clearing write, so an overload in that very cycle is not lost
  wire rov_clr = wr_rovreg & ~w_byte_r[rmlf_pkg::ROV_BIT];
  wire rov_set = ovl_nxt;
  wire rov_nxt  = rov_set | (rov_sticky_r & ~rov_clr);
  wire rx_overload_interrupt_flag_nxt = rov_set | (rx_overload_interrupt_flag_r & ~rov_clr);

  wire [rmlf_pkg::IRQ_W-1:0] irq_set;
  assign irq_set[rmlf_pkg::IRQ_OVL_BIT]  = ovl_nxt & ~live_d_r[0];
  assign irq_set[rmlf_pkg::IRQ_DOD_BIT]  = dod_nxt & ~live_d_r[1];
  assign irq_set[rmlf_pkg::IRQ_OPD_BIT]  = opd_nxt & ~live_d_r[2];
  assign irq_set[rmlf_pkg::IRQ_RING_BIT] = ring_nxt & ~ring_out_r;

  // read clears, but an event in the same cycle survives
  wire rd_status = ar_take && (ar_idx == rmlf_pkg::IDX_IRQ_STATUS);
  wire [rmlf_pkg::IRQ_W-1:0] irq_status_nxt =
    irq_set | (rd_status ? {rmlf_pkg::IRQ_W{1'b0}} : irq_status_r);

  // registered so the pin cannot glitch while status and mask change together
  wire [rmlf_pkg::IRQ_W-1:0] irq_mask_nxt = wr_mask ? w_byte_r[rmlf_pkg::IRQ_W-1:0] : irq_mask_r;
  assign irq = irq_r;

  // ************************************************************
  // read mux
  // ************************************************************
  // reserved positions read as zero, though ring_mode_r and line_ctrl_r store all eight written bits
  wire [7:0] ring_rd   = {5'h00, ring_mode_r[rmlf_pkg::RING_SPARE_BIT],
                          ring_mode_r[rmlf_pkg::RING_FW_BIT], 1'b0};
  wire [7:0] status_rd = {5'h00, ovl_live_r, dod_r, opd_r};
  wire [7:0] rov_rd    = {6'h00, rov_sticky_r, rx_overload_interrupt_flag_r};
  wire [7:0] ctrl_rd   = {5'h00, line_ctrl_r[2:0]};
  wire [7:0] stat_rd   = {4'h0, irq_status_r};
  wire [7:0] mask_rd   = {4'h0, irq_mask_r};

  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    if (ar_idx == rmlf_pkg::IDX_RING_MODE) begin
      rd_byte = ring_rd;
    end else if (ar_idx == rmlf_pkg::IDX_LINE_STATUS) begin
      rd_byte = status_rd;
    end else if (ar_idx == rmlf_pkg::IDX_IRQ_STATUS) begin
      rd_byte = stat_rd;
    end else if (ar_idx == rmlf_pkg::IDX_IRQ_MASK) begin
      rd_byte = mask_rd;
    end else if (ar_idx == rmlf_pkg::IDX_RX_OVL) begin
      rd_byte = rov_rd;
    end else if (ar_idx == rmlf_pkg::IDX_LINE_CTRL) begin
      rd_byte = ctrl_rd;
    end else begin
      rd_byte = rmlf_pkg::BYTE_ZERO;
      rd_hit  = 1'b0;
    end
  end

  // ************************************************************
  // state update
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_idx_r  <= 6'h00;
      w_byte_r  <= rmlf_pkg::REG_RESET;
      w_lane0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= rmlf_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= rmlf_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_idx_r  <= aw_idx;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (w_take) begin
        w_have_r  <= 1'b1;
        w_byte_r  <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? rmlf_pkg::RESP_OKAY : rmlf_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h000000, rd_byte};
        rresp_r  <= rd_hit ? rmlf_pkg::RESP_OKAY : rmlf_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ring_mode_r  <= rmlf_pkg::REG_RESET;
      line_ctrl_r  <= rmlf_pkg::REG_RESET;
      irq_mask_r   <= {rmlf_pkg::IRQ_W{1'b0}};
      irq_status_r <= {rmlf_pkg::IRQ_W{1'b0}};
      rov_sticky_r <= 1'b0;
      rx_overload_interrupt_flag_r       <= 1'b0;
      live_d_r     <= 3'h0;
      ring_out_r   <= 1'b0;
      ovl_live_r   <= 1'b0;
      dod_r        <= 1'b0;
      opd_r        <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      if (wr_ring) begin
        ring_mode_r <= w_byte_r;
      end
      if (wr_ctrl) begin
        line_ctrl_r <= w_byte_r;
      end
      irq_mask_r   <= irq_mask_nxt;
      irq_status_r <= irq_status_nxt;
      rov_sticky_r <= rov_nxt;
      rx_overload_interrupt_flag_r       <= rx_overload_interrupt_flag_nxt;
      live_d_r     <= {opd_nxt, dod_nxt, ovl_nxt};
      ring_out_r   <= ring_nxt;
      ovl_live_r   <= ovl_nxt;
      dod_r        <= dod_nxt;
      opd_r        <= opd_nxt;
      irq_r        <= |(irq_status_nxt & irq_mask_nxt);
    end
  end

  assign ring_detect_output = ring_out_r;

endmodule

// >>> logic/rmlf_pkg.sv
package rmlf_pkg;

  // ************************************************************
  // register indices; byte address is four times the index
  // ************************************************************
  localparam logic [5:0] IDX_RING_MODE   = 6'h12;
  localparam logic [5:0] IDX_LINE_STATUS = 6'h13;
  localparam logic [5:0] IDX_IRQ_STATUS  = 6'h20;
  localparam logic [5:0] IDX_IRQ_MASK    = 6'h21;
  localparam logic [5:0] IDX_RX_OVL      = 6'h22;
  localparam logic [5:0] IDX_LINE_CTRL   = 6'h23;

  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int RING_FW_BIT    = 1;
  localparam int RING_SPARE_BIT = 2;
  localparam int OVL_BIT        = 2;
  localparam int DOD_BIT        = 1;
  localparam int OPD_BIT        = 0;
  localparam int ROV_BIT        = 1;
  localparam int RX_OVERLOAD_INTERRUPT_FLAG_BIT       = 0;
  localparam int CTL_RING_VALIDATION_ENABLE_BIT   = 0;
  localparam int CTL_BTE_BIT    = 1;
  localparam int CTL_CURRENT_LIMIT_SELECT_BIT   = 2;
  localparam int IRQ_OVL_BIT    = 0;
  localparam int IRQ_DOD_BIT    = 1;
  localparam int IRQ_OPD_BIT    = 2;
  localparam int IRQ_RING_BIT   = 3;
  localparam int IRQ_W          = 4;

  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ         = 125;
  localparam int ONESHOT_US      = 1000;
  localparam int ONESHOT_CYCLES  = ONESHOT_US * CLK_MHZ;
  localparam int OVERCURRENT_MA  = 160;
  localparam int SYNC_W          = 10;

  typedef enum logic [1:0] {
    RING_HALF_WAVE,
    RING_FULL_WAVE,
    RING_VALID_ENV,
    RING_ONE_SHOT
  } rmlf_ring_sel_type;

  // analog-side status lines, all asynchronous to aclk
  typedef struct packed {
    logic ring_halfwave;
    logic ring_fullwave;
    logic ring_valid_env;
    logic ring_threshold_cross;
    logic rx_level_excess;
    logic offhook_count_done;
    logic loop_current;
    logic offhook;
    logic line_side_enabled;
    logic overcurrent;
  } rmlf_line_in_type;

endpackage

// >>> logic/rmlf_oneshot.sv
`timescale 1ns/10ps
module rmlf_oneshot #(
  parameter int CYCLES = rmlf_pkg::ONESHOT_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic trigger,
  output logic      pulse
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  logic          trig_d_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire           rise = trigger & ~trig_d_r;

  // not retriggerable: a crossing while running is ignored, so pulse length is fixed
  assign cnt_nxt = (cnt_r != CNT_ZERO) ? cnt_r - CNT_ONE : (rise ? CNT_LOAD : CNT_ZERO);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_d_r <= 1'b0;
      cnt_r    <= CNT_ZERO;
    end else begin
      trig_d_r <= trigger;
      cnt_r    <= cnt_nxt;
    end
  end

  assign pulse = (cnt_r != CNT_ZERO);
endmodule

// >>> test/rmlf_sva.sv
`timescale 1ns/10ps
module rmlf_sva (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [7:0]                 s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire rmlf_pkg::rmlf_line_in_type line_in
);
  // ************************************************************
  // line stability tracker
  // ************************************************************
  // status reads are only judged once the pins have settled past the synchronisers
  logic [2:0]                 stab_r;
  rmlf_pkg::rmlf_line_in_type line_q_r;
  always_ff @(posedge aclk) begin
    line_q_r <= line_in;
    if (!aresetn || line_in != line_q_r) stab_r <= 3'h0;
    else if (stab_r != 3'h7) stab_r <= stab_r + 3'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_stat_rd;
    s_ar_take ##0 (s_axi_araddr == 8'h4c && stab_r > 3'h2);
  endsequence
  sequence s_bad_rd;
    s_ar_take ##0 !(s_axi_araddr[7:2] inside {6'h12, 6'h13, [6'h20:6'h23]});
  endsequence

  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_rd_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_ovl_live: assert property (
    s_stat_rd |=> s_axi_rdata[2] == ($past(line_q_r.rx_level_excess) && $past(line_q_r.offhook_count_done)))
    else $error("live overload flag wrong");
  chk_dod_flag: assert property (
    s_stat_rd |=> s_axi_rdata[1] == ($past(line_q_r.offhook) ? !$past(line_q_r.loop_current) :
                                     $past(line_q_r.line_side_enabled)))
    else $error("dropout flag wrong");
  chk_opd_flag: assert property (s_stat_rd |=> s_axi_rdata[0] == $past(line_q_r.overcurrent))
    else $error("overcurrent flag wrong");
  chk_bad_rd: assert property (s_bad_rd |=> s_axi_rresp == rmlf_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind rmlf_top rmlf_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .line_in(line_in)
);

// >>> test/rmlf_tb_top.sv
`timescale 1ns/10ps
module rmlf_tb_top;
  localparam int         OS   = 8;
  localparam logic [7:0] A_RM = {rmlf_pkg::IDX_RING_MODE, 2'h0};
  localparam logic [7:0] A_ST = {rmlf_pkg::IDX_LINE_STATUS, 2'h0};
  localparam logic [7:0] A_IS = {rmlf_pkg::IDX_IRQ_STATUS, 2'h0};
  localparam logic [7:0] A_IM = {rmlf_pkg::IDX_IRQ_MASK, 2'h0};
  localparam logic [7:0] A_OV = {rmlf_pkg::IDX_RX_OVL, 2'h0};
  localparam logic [7:0] A_LC = {rmlf_pkg::IDX_LINE_CTRL, 2'h0};
  localparam logic [1:0] OK   = rmlf_pkg::RESP_OKAY;
  localparam logic [1:0] SE   = rmlf_pkg::RESP_SLVERR;
  logic                       aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]                 awaddr = 8'h0, araddr = 8'h0;
  logic [31:0]                wdata = 32'h0, rdata, rnd;
  logic                       awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                       awready, wready, bvalid, arready, rvalid, rdo, clim, irq;
  logic [1:0]                 bresp, rresp;
  rmlf_pkg::rmlf_line_in_type li = '0;
  int                         err_count = 0, num_checks = 0, i, m, n;
  logic [7:0]                 adr [6];

  rmlf_top #(.ONESHOT_CYCLES(OS)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_in(li),
    .ring_detect_output(rdo), .current_limit_select(clim), .irq(irq)
  );

  initial begin
    forever #4 aclk = ~aclk;
  end

  // ************************************************************
  // expectations and bus tasks
  // ************************************************************
  function automatic logic [7:0] st_exp(input rmlf_pkg::rmlf_line_in_type l);
    return {5'h0, l.rx_level_excess & l.offhook_count_done,
            l.offhook ? ~l.loop_current : l.line_side_enabled, l.overcurrent};
  endfunction

  function automatic logic ring_exp(input logic [1:0] md, input rmlf_pkg::rmlf_line_in_type l);
    return md == 2'h0 ? l.ring_halfwave : md == 2'h1 ? l.ring_fullwave : l.ring_valid_env;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // address and data are offered together; each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok = aw_ok || (awvalid && awready);
      w_ok = w_ok || (wvalid && wready);
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    // a late ready now and then keeps the response-hold checks busy
    repeat ($urandom % 3) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er, input bit skip = 1'b0);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    repeat ($urandom % 3) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    if (!skip) begin
      check("rdata", rdata, {24'h0, exp});
      check("rresp", rresp, er);
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    adr = '{A_RM, A_ST, A_IS, A_IM, A_OV, A_LC};
    void'($urandom(32'h15ff2eab));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i++) rd(adr[i], 8'h00, OK);
    check("irq", irq, 32'h0);
    $display("test reset values done");
    for (m = 0; m < 3; m++) begin
      rnd = $urandom;
      wr(A_LC, {7'h0, m[1]}, OK);
      wr(A_RM, {5'h0, rnd[0], m[0], 1'b0}, OK);
      rd(A_RM, {5'h0, rnd[0], m[0], 1'b0}, OK);
      repeat (6) begin
        li <= 10'($urandom);
        repeat (4) @(posedge aclk);
        check("ring", rdo, ring_exp(m[1:0], li));
      end
    end
    wr(A_LC, 8'h01, OK);
    wr(A_RM, 8'h02, OK);
    li <= '0;
    repeat (16) @(posedge aclk);
    li.ring_threshold_cross <= 1'b1;
    n = 0;
    for (i = 0; i < 10 && !rdo; i++) @(posedge aclk);
    while (rdo && n < 40) begin
      n++;
      @(posedge aclk);
    end
    check("oneshot", n, OS);
    $display("test ring modes done");
    for (i = 0; i < 24; i++) begin
      rnd = $urandom;
      wr(A_LC, {5'h0, rnd[11:10], 1'b0}, OK);
      li <= i == 0 ? 10'h002 : i == 1 ? 10'h3ff : rnd[9:0];
      repeat (4) @(posedge aclk);
      rd(A_ST, st_exp(li), OK);
      check("clim", clim, rnd[11]);
    end
    $display("test line status done");
    li <= '0;
    repeat (4) @(posedge aclk);
    rd(A_IS, 8'h00, OK, 1'b1);
    wr(A_OV, 8'h00, OK);
    wr(A_IM, 8'h00, OK);
    li <= 10'h030;
    repeat (4) @(posedge aclk);
    rd(A_OV, 8'h03, OK);
    check("irq", irq, 32'h0);
    wr(A_IM, 8'h01, OK);
    check("irq", irq, 32'h1);
    rd(A_IS, 8'h01, OK);
    check("irq", irq, 32'h0);
    rd(A_IM, 8'h01, OK);
    li <= '0;
    repeat (4) @(posedge aclk);
    rd(A_ST, 8'h00, OK);
    rd(A_OV, 8'h03, OK);
    wr(A_OV, 8'h00, OK);
    rd(A_OV, 8'h00, OK);
    wr(8'h40, 8'h5a, SE);
    rd(8'h40, 8'h00, SE);
    $display("test overload and interrupt done");
    stop_test();
  end

  // the whole run needs well under a thousand cycles; this bounds any hang
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    stop_test();
  end
endmodule
